// File: blfm_pkg.sv
// Purpose: shared constants and types for the backlight fault monitor
// Assumes: 25 MHz reference clock
// Notes:   flag bit positions follow the fault flag byte layout
`default_nettype none
package blfm_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 25000000;
    localparam int OVP_PERSIST_US  = 1000;
    localparam int OCP_WINDOW_US   = 128;
    localparam int BLANK_US        = 4000;
    localparam int OVP_PERSIST_CYC = (OVP_PERSIST_US * (CLK_HZ / 1000000));
    localparam int OCP_WINDOW_CYC  = (OCP_WINDOW_US * (CLK_HZ / 1000000));
    localparam int BLANK_CYC       = (BLANK_US * (CLK_HZ / 1000000));
    localparam int OVP_OPEN_COUNT  = 3;
    localparam int OCP_MIN_EVENTS  = 2;
    localparam int OCP_WINDOWS     = 8;
    // ------------------------------------------------------------
    // addresses and field positions
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_LOW  = 7'h36;
    localparam logic [6:0] ADDR_HIGH = 7'h37;
    localparam int FLAG_OVP   = 0;
    localparam int FLAG_OCP   = 1;
    localparam int FLAG_SHORT = 3;
    localparam int FLAG_OPEN  = 4;
    localparam int SD_OVP     = 0;
    localparam int SD_OCP     = 1;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // switching frequency choices
    typedef enum logic [2:0] {
        BLFM_F250K = 3'b001,
        BLFM_F500K = 3'b010,
        BLFM_F1M   = 3'b100
    } blfm_freq_e;
    // analog comparator events
    typedef struct packed {
        logic ovp_hit;
        logic ocp_hit;
        logic [2:0] sink_low;
        logic [2:0] short_hit;
    } blfm_comp_s;
endpackage
`default_nettype wire

// File: blfm_ocp_density.sv
// Purpose: overcurrent pulse density counter over fixed windows
// Assumes: one event pulse per overcurrent hit
// Notes:   events in the blank interval are not counted
`default_nettype none
module blfm_ocp_density (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic event_hit,
    input  wire logic blank,
    output logic      trip
);
    logic [12:0] win_cnt, next_win_cnt;
    logic [1:0]  ev_cnt, next_ev_cnt;
    logic [3:0]  run, next_run;
    logic        next_trip;
    // ------------------------------------------------------------
    // window counting
    // ------------------------------------------------------------
    // density window and run of dense windows
    always_comb begin
        next_win_cnt = win_cnt + 13'h1;
        next_ev_cnt  = ev_cnt;
        next_run     = run;
        next_trip    = 1'b0;
        if (event_hit && !blank && ev_cnt != 2'h2) begin
            next_ev_cnt = ev_cnt + 2'h1;
        end
        if (blank) begin
            next_win_cnt = 13'h0;
            next_ev_cnt  = 2'h0;
            next_run     = 4'h0;
        end else if (win_cnt == 13'(blfm_pkg::OCP_WINDOW_CYC - 1)) begin
            next_win_cnt = 13'h0;
            if (next_ev_cnt >= 2'(blfm_pkg::OCP_MIN_EVENTS)) begin
                next_run = (run == 4'(blfm_pkg::OCP_WINDOWS - 1)) ? 4'h0 : run + 4'h1;
                next_trip = (run == 4'(blfm_pkg::OCP_WINDOWS - 1));
            end else begin
                next_run = 4'h0;
            end
            // cleared only after the last cycle's event was judged
            next_ev_cnt  = 2'h0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            win_cnt <= 13'h0;
            ev_cnt  <= 2'h0;
            run     <= 4'h0;
            trip    <= 1'b0;
        end else begin
            win_cnt <= next_win_cnt;
            ev_cnt  <= next_ev_cnt;
            run     <= next_run;
            trip    <= next_trip;
        end
    end
endmodule
`default_nettype wire

// File: blfm_monitor.sv
// Purpose: fault supervision, frequency mode and address strap of a backlight boost driver
// Assumes: comparator inputs are synchronous to REF_CLK; one-cycle event pulses
// Notes:   flags are sticky and clear on the flag read strobe
//          the strap is taken on the first edge after reset
//          a fault halt is left by a read and enable low, in either order
//          overcurrent events count only after the blank
`default_nettype none
module blfm_monitor (
    input  wire logic              REF_CLK,
    input  wire logic              RESET_N,
    input  wire logic              ADDRESS_SELECT_PIN,
    input  wire logic [7:0]        AUTO_HIGH_THRESH,
    input  wire logic [7:0]        AUTO_LOW_THRESH,
    input  wire logic [7:0]        BRIGHTNESS_MSB,
    input  wire logic              BRIGHTNESS_CHANGE,
    input  wire logic              FREQ_SELECT,
    input  wire logic [1:0]        OVP_SELECT_IN,
    input  wire logic [1:0]        OCP_SELECT_IN,
    input  wire logic [2:0]        SINK_ENABLE,
    input  wire logic              SHORT_DETECT_ENABLE,
    input  wire logic              SHUTDOWN_ON_OVP,
    input  wire logic              SHUTDOWN_ON_OCP,
    input  wire logic              DEVICE_ENABLE,
    input  wire logic              FLAGS_READ,
    input  wire blfm_pkg::blfm_comp_s COMP,
    input  wire logic              OVP_CLEAR,
    input  wire logic              PERIOD_START,
    output logic [6:0]             SLAVE_ADDRESS,
    output logic [7:0]             FAULT_FLAGS,
    output blfm_pkg::blfm_freq_e   SWITCH_FREQ,
    output logic                   BOOST_RUN,
    output logic                   SWITCH_GATE,
    output logic                   DEVICE_ACTIVE,
    output logic [1:0]             OVP_SELECT,
    output logic [1:0]             OCP_SELECT
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_RUN  = 3'b010,
        ST_HALT = 3'b100
    } blfm_state_e;

    blfm_state_e          state, next_state;
    logic                 strap_done, next_strap_done;
    logic [6:0]           next_slave_address;
    logic [7:0]           next_fault_flags;
    blfm_pkg::blfm_freq_e next_switch_freq;
    logic                 next_boost_run, next_switch_gate, next_device_active;
    // overvoltage hold, timer and trip count
    logic                 ovp_hold, next_ovp_hold;
    logic [14:0]          ovp_cnt, next_ovp_cnt;
    logic [1:0]           trip_cnt, next_trip_cnt;
    // blank timer and halt bookkeeping
    logic [16:0]          blank_cnt, next_blank_cnt;
    logic                 read_seen, next_read_seen;
    // helpers
    logic                 ocp_trip;
    logic                 blank;
    logic                 sink_low_any;
    logic                 ovp_long;

    // decode of any enabled sink showing a condition
    function automatic logic any_enabled(input logic [2:0] cond, input logic [2:0] en);
        any_enabled = |(cond & en);
    endfunction

    // shared by the flag logic below
    assign sink_low_any = any_enabled(COMP.sink_low, SINK_ENABLE);
    assign blank        = (blank_cnt != 17'h0);
    assign ovp_long     = (ovp_cnt == 15'(blfm_pkg::OVP_PERSIST_CYC));

    // ------------------------------------------------------------
    // overcurrent density counter
    // ------------------------------------------------------------
    // same blank as the flag logic sees
    // blanked events ignored
    blfm_ocp_density u_density (
        .clk       (REF_CLK),
        .rst_n     (RESET_N),
        .event_hit (COMP.ocp_hit),
        .blank     (blank),
        .trip      (ocp_trip)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // one process keeps the set-over-clear order in view
    // all supervision state but the density counter computed here, registered below
    always_comb begin
        // defaults hold every value but strap_done, which is set, and the frequency and run outputs, always assigned below
        next_state         = state;
        next_strap_done    = 1'b1;
        next_slave_address = SLAVE_ADDRESS;
        next_fault_flags   = FAULT_FLAGS;
        next_ovp_hold      = ovp_hold;
        next_ovp_cnt       = ovp_cnt;
        next_trip_cnt      = trip_cnt;
        next_blank_cnt     = blank_cnt;
        next_read_seen     = read_seen;
        next_switch_gate   = SWITCH_GATE;

        // strap_done stays high until reset, pin moves ignored
        // strap captured once
        if (!strap_done) begin
            next_slave_address = ADDRESS_SELECT_PIN ? blfm_pkg::ADDR_HIGH : blfm_pkg::ADDR_LOW;
        end

        // high threshold tested first, it wins an overlap
        // frequency choice
        if (AUTO_HIGH_THRESH != 8'h00 || AUTO_LOW_THRESH != 8'h00) begin
            if (BRIGHTNESS_MSB >= AUTO_HIGH_THRESH) begin
                next_switch_freq = blfm_pkg::BLFM_F1M;
            end else if (BRIGHTNESS_MSB < AUTO_LOW_THRESH) begin
                next_switch_freq = blfm_pkg::BLFM_F250K;
            end else begin
                next_switch_freq = blfm_pkg::BLFM_F500K;
            end
        end else begin
            next_switch_freq = FREQ_SELECT ? blfm_pkg::BLFM_F1M : blfm_pkg::BLFM_F500K;
        end

        // clear first, so any later set overrides it
        // read clears flags; set wins below
        if (FLAGS_READ) begin
            next_fault_flags = blfm_pkg::FLAGS_RESET;
            next_read_seen   = 1'b1;
        end

        // a trip with the clear keeps the hold
        // hold switching off until output falls
        if (COMP.ovp_hit) begin
            next_ovp_hold = 1'b1;
        end else if (OVP_CLEAR) begin
            next_ovp_hold = 1'b0;
        end

        // timer saturates, a long excursion flags once
        // persistence timer
        if (!COMP.ovp_hit) begin
            next_ovp_cnt = 15'h0;
        end else if (!ovp_long) begin
            next_ovp_cnt = ovp_cnt + 15'h1;
        end
        if (ovp_cnt == 15'(blfm_pkg::OVP_PERSIST_CYC - 1) && COMP.ovp_hit) begin
            next_fault_flags[blfm_pkg::FLAG_OVP] = 1'b1;
            if (sink_low_any) begin
                next_fault_flags[blfm_pkg::FLAG_OPEN] = 1'b1;
            end
        end

        // a held trip is one occurrence, not many
        // the count survives a flag read
        // count trip onsets with a low sink
        if (COMP.ovp_hit && !ovp_hold && sink_low_any) begin
            if (trip_cnt == 2'(blfm_pkg::OVP_OPEN_COUNT - 1)) begin
                next_trip_cnt = 2'h0;
                next_fault_flags[blfm_pkg::FLAG_OVP]  = 1'b1;
                next_fault_flags[blfm_pkg::FLAG_OPEN] = 1'b1;
            end else begin
                next_trip_cnt = trip_cnt + 2'h1;
            end
        end

        // with several strings on, one sink can mask another
        // headroom short
        if (SHORT_DETECT_ENABLE && any_enabled(COMP.short_hit, SINK_ENABLE)) begin
            next_fault_flags[blfm_pkg::FLAG_SHORT] = 1'b1;
        end

        if (ocp_trip) begin
            next_fault_flags[blfm_pkg::FLAG_OCP] = 1'b1;
        end

        // a current hit wins over a period start
        // cut switch for rest of period
        if (COMP.ocp_hit) begin
            next_switch_gate = 1'b0;
        end else if (PERIOD_START) begin
            next_switch_gate = 1'b1;
        end

        // held loaded while off, so every start-up is blanked
        // blank timer restarts on start-up and brightness change
        if (BRIGHTNESS_CHANGE || state == ST_OFF) begin
            next_blank_cnt = 17'(blfm_pkg::BLANK_CYC);
        end else if (blank) begin
            next_blank_cnt = blank_cnt - 17'h1;
        end

        // halt is left only through off, a held enable stays out
        // enable and shutdown sequencing
        case (state)
            // leaving off starts the blank
            ST_OFF: begin
                if (DEVICE_ENABLE) begin
                    next_state = ST_RUN;
                end
            end
            // a dropped enable wins over a fault
            ST_RUN: begin
                if (!DEVICE_ENABLE) begin
                    next_state = ST_OFF;
                end else if ((SHUTDOWN_ON_OVP && (next_fault_flags[blfm_pkg::FLAG_OVP] ||
                              next_fault_flags[blfm_pkg::FLAG_OPEN])) ||
                             (SHUTDOWN_ON_OCP && next_fault_flags[blfm_pkg::FLAG_OCP])) begin
                    next_state     = ST_HALT;
                    next_read_seen = 1'b0;
                end
            end
            // the read may meet the enable drop
            ST_HALT: begin
                if ((read_seen || FLAGS_READ) && !DEVICE_ENABLE) begin
                    next_state = ST_OFF;
                end
            end
            // illegal code falls back to off
            default: begin
                next_state = ST_OFF;
            end
        endcase

        // next values, so outputs follow the cause by one cycle
        next_device_active = (next_state == ST_RUN);
        next_boost_run     = next_device_active && !next_ovp_hold;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // no clock enable, every flop updates each edge
    // synchronous reset; the strap is sampled on the first edge after release
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            // every flop set to its reset value, the strap included
            state         <= ST_OFF;
            strap_done    <= 1'b0;
            SLAVE_ADDRESS <= blfm_pkg::ADDR_LOW;
            FAULT_FLAGS   <= blfm_pkg::FLAGS_RESET;
            SWITCH_FREQ   <= blfm_pkg::BLFM_F500K;
            BOOST_RUN     <= 1'b0;
            SWITCH_GATE   <= 1'b0;
            DEVICE_ACTIVE <= 1'b0;
            ovp_hold      <= 1'b0;
            ovp_cnt       <= 15'h0;
            trip_cnt      <= 2'h0;
            blank_cnt     <= 17'h0;
            read_seen     <= 1'b0;
            OVP_SELECT    <= 2'h0;
            OCP_SELECT    <= 2'h0;
        end else begin
            state         <= next_state;
            strap_done    <= next_strap_done;
            SLAVE_ADDRESS <= next_slave_address;
            FAULT_FLAGS   <= next_fault_flags;
            SWITCH_FREQ   <= next_switch_freq;
            BOOST_RUN     <= next_boost_run;
            SWITCH_GATE   <= next_switch_gate;
            DEVICE_ACTIVE <= next_device_active;
            ovp_hold      <= next_ovp_hold;
            ovp_cnt       <= next_ovp_cnt;
            trip_cnt      <= next_trip_cnt;
            blank_cnt     <= next_blank_cnt;
            read_seen     <= next_read_seen;

            // one flop only, decoding is left to the analog side
            // threshold selects to the analog side
            OVP_SELECT    <= OVP_SELECT_IN;
            OCP_SELECT    <= OCP_SELECT_IN;
        end
    end
endmodule
`default_nettype wire

// File: blfm_host_model.sv
// Purpose: host side model that configures the monitor and polls its flags
// Assumes: driven from the bench just after the clock edge
// Notes:   settle wait is shortened, the flags follow their cause by a cycle
`default_nettype none
module blfm_host_model #(
    parameter int SETTLE_CYC = 100
) (
    input  wire logic       clk,
    input  wire logic [7:0] fault_flags,
    output var logic        flags_read,
    output var logic        device_enable,
    output var logic [2:0]  sink_enable,
    output var logic        short_detect_enable,
    output var logic        shutdown_on_ovp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        flags_read = 1'b0;
        {device_enable, sink_enable, short_detect_enable, shutdown_on_ovp} = 6'h00;
    end
    // settings land together, then one edge passes
    task automatic cfg(input logic [2:0] s, input logic sd, input logic so, input logic en);
        {sink_enable, short_detect_enable, shutdown_on_ovp, device_enable} = {s, sd, so, en};
        @(posedge clk);
        #1;
    endtask
    task automatic read_flags(output logic [7:0] v);
        v = fault_flags;
        flags_read = 1'b1;
        @(posedge clk);
        #1;
        flags_read = 1'b0;
    endtask
    task automatic probe(input logic [2:0] s, input logic sd, output logic [7:0] v);
        cfg(s, sd, 1'b0, 1'b1);
        repeat (SETTLE_CYC) @(posedge clk);
        #1;
        read_flags(v);
        cfg(3'h0, 1'b0, 1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

// File: blfm_rules_monitor.sv
// Purpose: port level checks of the fault monitor
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto every monitor instance
`default_nettype none
module blfm_rules_chk (
    input wire logic                 REF_CLK,
    input wire logic                 RESET_N,
    input wire logic                 ADDRESS_SELECT_PIN,
    input wire logic [7:0]           AUTO_HIGH_THRESH,
    input wire logic [7:0]           AUTO_LOW_THRESH,
    input wire logic [7:0]           BRIGHTNESS_MSB,
    input wire logic                 FREQ_SELECT,
    input wire logic [1:0]           OVP_SELECT_IN,
    input wire logic [1:0]           OCP_SELECT_IN,
    input wire logic                 SHUTDOWN_ON_OVP,
    input wire logic                 DEVICE_ENABLE,
    input wire logic                 FLAGS_READ,
    input wire blfm_pkg::blfm_comp_s COMP,
    input wire logic                 PERIOD_START,
    input wire logic [6:0]           SLAVE_ADDRESS,
    input wire logic [7:0]           FAULT_FLAGS,
    input wire blfm_pkg::blfm_freq_e SWITCH_FREQ,
    input wire logic                 BOOST_RUN,
    input wire logic                 SWITCH_GATE,
    input wire logic                 DEVICE_ACTIVE,
    input wire logic [1:0]           OVP_SELECT,
    input wire logic [1:0]           OCP_SELECT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // consecutive overvoltage cycles, saturating so it never wraps
    logic [14:0] ovp_run;
    logic [14:0] next_ovp_run;
    always_comb begin
        next_ovp_run = COMP.ovp_hit ? ovp_run + {14'h0, ovp_run != 15'h7fff} : 15'h0;
    end
    always_ff @(posedge REF_CLK) begin
        ovp_run <= RESET_N ? next_ovp_run : 15'h0;
    end
    sequence s_shut;
        $fell(DEVICE_ACTIVE) && $past(DEVICE_ENABLE) && FAULT_FLAGS[0];
    endsequence
    sequence s_no_read;
        (!FLAGS_READ)[*4];
    endsequence
    property p_addr;
        $rose(RESET_N) |=> SLAVE_ADDRESS == {6'h1b, $past(ADDRESS_SELECT_PIN)};
    endproperty
    a_addr: assert property (p_addr) else $error("address strap mismatch");
    property p_addr_hold;
        $past(RESET_N, 2) |-> $stable(SLAVE_ADDRESS);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_fixed;
        AUTO_HIGH_THRESH == 8'h00 && AUTO_LOW_THRESH == 8'h00
            |=> SWITCH_FREQ == ($past(FREQ_SELECT) ? blfm_pkg::BLFM_F1M : blfm_pkg::BLFM_F500K);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed frequency wrong");
    property p_auto;
        AUTO_LOW_THRESH != 8'h00 && BRIGHTNESS_MSB < AUTO_LOW_THRESH && BRIGHTNESS_MSB < AUTO_HIGH_THRESH
            |=> SWITCH_FREQ == blfm_pkg::BLFM_F250K;
    endproperty
    a_auto: assert property (p_auto) else $error("low band frequency wrong");
    property p_sel;
        1'b1 |=> {OVP_SELECT, OCP_SELECT} == $past({OVP_SELECT_IN, OCP_SELECT_IN});
    endproperty
    a_sel: assert property (p_sel) else $error("threshold select wrong");
    property p_ovp_stop;
        COMP.ovp_hit |=> !BOOST_RUN;
    endproperty
    a_ovp_stop: assert property (p_ovp_stop) else $error("boost ran over threshold");
    property p_persist;
        COMP.ovp_hit && ovp_run == 15'h61a7 |=> FAULT_FLAGS[0];
    endproperty
    a_persist: assert property (p_persist) else $error("overvoltage flag late");
    property p_shut;
        $rose(FAULT_FLAGS[0]) && $past(SHUTDOWN_ON_OVP) && $past(DEVICE_ACTIVE) |-> !DEVICE_ACTIVE && !BOOST_RUN;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown on flag");
    property p_refuse;
        s_shut ##0 s_no_read |=> !DEVICE_ACTIVE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("restart before read");
    property p_gate;
        COMP.ocp_hit && !PERIOD_START |=> !SWITCH_GATE;
    endproperty
    a_gate: assert property (p_gate) else $error("switch left on");
    property p_sticky;
        !FLAGS_READ |=> (FAULT_FLAGS & $past(FAULT_FLAGS)) == $past(FAULT_FLAGS);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
endmodule
bind blfm_monitor blfm_rules_chk u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN), .AUTO_HIGH_THRESH(AUTO_HIGH_THRESH),
    .AUTO_LOW_THRESH(AUTO_LOW_THRESH), .BRIGHTNESS_MSB(BRIGHTNESS_MSB), .FREQ_SELECT(FREQ_SELECT),
    .OVP_SELECT_IN(OVP_SELECT_IN), .OCP_SELECT_IN(OCP_SELECT_IN), .SHUTDOWN_ON_OVP(SHUTDOWN_ON_OVP),
    .DEVICE_ENABLE(DEVICE_ENABLE), .FLAGS_READ(FLAGS_READ), .COMP(COMP), .PERIOD_START(PERIOD_START),
    .SLAVE_ADDRESS(SLAVE_ADDRESS), .FAULT_FLAGS(FAULT_FLAGS), .SWITCH_FREQ(SWITCH_FREQ),
    .BOOST_RUN(BOOST_RUN), .SWITCH_GATE(SWITCH_GATE), .DEVICE_ACTIVE(DEVICE_ACTIVE),
    .OVP_SELECT(OVP_SELECT), .OCP_SELECT(OCP_SELECT));
`default_nettype wire

// File: blfm_monitor_test.sv
// Purpose: self-checking bench for the backlight fault monitor
// Assumes: inputs change 1 ns after the rising edge
// Notes:   overcurrent density flag is left to the long blank, not run here
`default_nettype none
module blfm_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 ref_clk, reset_n, addr_pin, brt_change, freq_sel, ovp_clear, period_start;
    logic                 flags_read, dev_en, sdet, sd_ovp, sd_ocp, boost_run, gate, dev_active;
    logic [7:0]           auto_hi, auto_lo, msb, flags, v;
    logic [2:0]           sinks;
    logic [1:0]           ovp_in, ocp_in, ovp_sel, ocp_sel;
    logic [6:0]           slave_addr;
    blfm_pkg::blfm_comp_s comp;
    blfm_pkg::blfm_freq_e sw_freq;
    int                   err_count, samples_checked, seed, hi, lo;
    blfm_monitor u_dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .ADDRESS_SELECT_PIN(addr_pin),
        .AUTO_HIGH_THRESH(auto_hi), .AUTO_LOW_THRESH(auto_lo), .BRIGHTNESS_MSB(msb),
        .BRIGHTNESS_CHANGE(brt_change), .FREQ_SELECT(freq_sel), .OVP_SELECT_IN(ovp_in),
        .OCP_SELECT_IN(ocp_in), .SINK_ENABLE(sinks), .SHORT_DETECT_ENABLE(sdet),
        .SHUTDOWN_ON_OVP(sd_ovp), .SHUTDOWN_ON_OCP(sd_ocp), .DEVICE_ENABLE(dev_en),
        .FLAGS_READ(flags_read), .COMP(comp), .OVP_CLEAR(ovp_clear), .PERIOD_START(period_start),
        .SLAVE_ADDRESS(slave_addr), .FAULT_FLAGS(flags), .SWITCH_FREQ(sw_freq), .BOOST_RUN(boost_run),
        .SWITCH_GATE(gate), .DEVICE_ACTIVE(dev_active), .OVP_SELECT(ovp_sel), .OCP_SELECT(ocp_sel));
    blfm_host_model u_host (.clk(ref_clk), .fault_flags(flags), .flags_read(flags_read),
        .device_enable(dev_en), .sink_enable(sinks), .short_detect_enable(sdet),
        .shutdown_on_ovp(sd_ovp));
    // 40 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // reference frequency: fixed choice when both thresholds are zero
    function automatic logic [2:0] ref_freq(int h, int l, int m, logic fs);
        if (h == 0 && l == 0) return fs ? blfm_pkg::BLFM_F1M : blfm_pkg::BLFM_F500K;
        if (m >= h) return blfm_pkg::BLFM_F1M;
        if (m < l) return blfm_pkg::BLFM_F250K;
        return blfm_pkg::BLFM_F500K;
    endfunction
    // strap moves after release to show it is held
    task automatic do_reset(input logic pin);
        reset_n = 1'b0;
        addr_pin = pin;
        step(4);
        reset_n = 1'b1;
        step(2);
        addr_pin = ~pin;
        step(2);
        chk({1'b0, slave_addr}, pin ? 8'h37 : 8'h36);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, the whole run needs about 2.05 ms
    initial begin
        #3ms;
        err_count++;
        tally_and_finish();
    end
    initial begin
        seed = 32'h4bd1;
        {brt_change, freq_sel, ovp_clear, period_start, sd_ocp} = 5'h00;
        {auto_hi, auto_lo, msb, ovp_in, ocp_in} = 28'h0;
        comp = '0;
        do_reset(1'b0);
        do_reset(1'b1);
        // every fourth pass turns auto mode off
        for (int i = 0; i < 24; i++) begin
            lo = (i % 4 == 0) ? 0 : $unsigned($random(seed)) % 128;
            hi = (i % 4 == 0) ? 0 : lo + 1 + $unsigned($random(seed)) % 127;
            {auto_hi, auto_lo} = {hi[7:0], lo[7:0]};
            msb = 8'($random(seed));
            freq_sel = 1'($random(seed));
            step(2);
            chk({5'h0, sw_freq}, {5'h0, ref_freq(hi, lo, msb, freq_sel)});
        end
        for (int i = 0; i < 4; i++) begin
            {ovp_in, ocp_in} = {i[1:0], ~i[1:0]};
            step(1);
            chk({4'h0, ovp_sel, ocp_sel}, {4'h0, i[1:0], ~i[1:0]});
        end
        u_host.cfg(3'h7, 1'b0, 1'b0, 1'b1);
        step(2);
        // four trips, the first with healthy sinks
        for (int i = 0; i < 4; i++) begin
            comp.sink_low = (i == 0) ? 3'h0 : 3'h4;
            comp.ovp_hit = 1'b1;
            step(1);
            chk({7'h0, boost_run}, 8'h00);
            {comp.ovp_hit, ovp_clear} = 2'b01;
            step(2);
            ovp_clear = 1'b0;
            chk({7'h0, boost_run}, 8'h01);
            chk(flags, (i == 3) ? 8'h11 : 8'h00);
        end
        chk({7'h0, dev_active}, 8'h01);
        comp.sink_low = 3'h0;
        u_host.read_flags(v);
        chk(v, 8'h11);
        chk(flags, 8'h00);
        u_host.cfg(3'h7, 1'b0, 1'b1, 1'b1);
        comp.ovp_hit = 1'b1;
        step(24999);
        chk(flags, 8'h00);
        step(1);
        chk(flags, 8'h01);
        chk({7'h0, dev_active}, 8'h00);
        {comp.ovp_hit, ovp_clear} = 2'b01;
        // restart is tried before and after the read
        for (int i = 0; i < 2; i++) begin
            u_host.cfg(3'h7, 1'b0, 1'b1, 1'b0);
            u_host.cfg(3'h7, 1'b0, 1'b1, 1'b1);
            step(2);
            chk({7'h0, dev_active}, i[7:0]);
            u_host.read_flags(v);
        end
        comp.short_hit = 3'h2;
        u_host.probe(3'h1, 1'b1, v);
        chk(v, 8'h00);
        u_host.probe(3'h2, 1'b1, v);
        chk(v, 8'h08);
        comp.short_hit = 3'h0;
        u_host.cfg(3'h7, 1'b0, 1'b0, 1'b1);
        // gate opens on a period start, shuts on a current hit; first pass changes brightness
        for (int i = 0; i < 3; i++) begin
            {period_start, comp.ocp_hit, brt_change} = {i[0] == 1'b0, i == 1, i == 0};
            step(1);
            {period_start, comp.ocp_hit} = 2'b00;
            step(1);
            chk({7'h0, gate}, {7'h0, i != 1});
        end
        // dense current hits over eight windows, all inside the blank
        {comp.ocp_hit, sd_ocp} = 2'b11;
        step(26000);
        comp.ocp_hit = 1'b0;
        step(2);
        chk(flags & 8'h02, 8'h00);
        chk({7'h0, dev_active}, 8'h01);
        tally_and_finish();
    end
endmodule
`default_nettype wire
